/* File: hw/pmic_pkg.sv */
// Behaviour
// - From power-up only the always-on rail is enabled; every other rail stays off.
// - Once the always-on rail is good, raise supply-good to free the clock-domain reset.
// - A low full-power request starts power-down; processor may drop it any time.
// - Rails come up by strobe: 15, then 1, 2, 3, 4, then 5.
// - After all sequenced rails are up, drive all-rails-good high.
// - A wake event such as a button press asserts the wake output.
// - A button press pulls the open-drain interrupt low until acknowledged.
// - Power indicator turns on after a complete power-up, and for one flash after a power-up fault.
// - A fault during power-up shuts down and flashes the indicator exactly once.
// - Configuration writes switch rails on or off and set regulator voltages.
// - Processor rail voltage resets to 1.1V and may be raised by writes.
// - Memory rail voltage resets to 1.5V and may be lowered to 1.35V.
// - Clock-only low power keeps the always-on rail and wake detection alive.
// - Clock-plus-memory low power keeps always-on and memory rails and wake detection.
// - Button held longer than 8 seconds powers the device down.
package pmic_pkg;
  // ****************************************************************
  // Rails, strobes and voltage codes
  // ****************************************************************
  localparam int RAILS = 7;
  localparam int RAIL_AO = 0;
  localparam int RAIL_MEM = 1;
  localparam int RAIL_LOW_IO = 2;
  localparam int RAIL_IO_PRI = 3;
  localparam int RAIL_IO_SEC = 4;
  localparam int RAIL_CORE = 5;
  localparam int RAIL_MPU = 6;
  // Step per rail; step 0 stands for strobe 15, which is up from power-up
  localparam logic [20:0] RAIL_STEP = {3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [2:0] FIRST_STEP = 3'h1;
  localparam logic [2:0] LAST_STEP = 3'h5;
  localparam logic [6:0] AO_MASK = 7'h01;
  localparam logic [6:0] RAIL_SW_RST = 7'h7f;
  // Voltage codes in 50 mV units
  localparam logic [6:0][7:0] VSEL_RST = {8'h16, 8'h16, 8'h42, 8'h42, 8'h24, 8'h1e, 8'h24};
  localparam logic [7:0] VSEL_MEM_LOW = 8'h1b;
  // Configuration write addresses
  localparam logic [3:0] CFG_RAIL_SW = 4'h0;
  localparam logic [3:0] CFG_VSEL_FIRST = 4'h1;
  localparam logic [3:0] CFG_VSEL_LAST = 4'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 250000000;
  localparam longint DEB_US = 10000;
  localparam longint DEB_CYC = (DEB_US * CLK_HZ + 999999) / 1000000;
  localparam longint STROBE_US = 2000;
  localparam longint STROBE_CYC = (STROBE_US * CLK_HZ + 999999) / 1000000;
  localparam longint GOOD_TO_MS = 50;
  localparam longint GOOD_TO_CYC = (GOOD_TO_MS * CLK_HZ + 999) / 1000;
  localparam longint FLASH_MS = 250;
  localparam longint FLASH_CYC = (FLASH_MS * CLK_HZ) / 1000;
  localparam longint LONG_PRESS_MS = 8000;
  localparam longint LONG_PRESS_CYC = (LONG_PRESS_MS * CLK_HZ + 999) / 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [7:0] data;
  } pmic_cfg_wr_t;

  typedef enum logic [2:0] {S_AO_UP, S_IDLE, S_STROBE, S_ON, S_FAULT} pmic_state_t;
endpackage : pmic_pkg

/* File: hw/pmic_seq.sv */
`timescale 1ns/1ps
module pmic_seq #(
  parameter int unsigned DEB_CYC = 32'(pmic_pkg::DEB_CYC),
  parameter int unsigned STROBE_CYC = 32'(pmic_pkg::STROBE_CYC),
  parameter int unsigned GOOD_TO_CYC = 32'(pmic_pkg::GOOD_TO_CYC),
  parameter int unsigned FLASH_CYC = 32'(pmic_pkg::FLASH_CYC),
  parameter int unsigned LONG_PRESS_CYC = 32'(pmic_pkg::LONG_PRESS_CYC)
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic full_power_request_pin_i,
  input wire logic button_n_i,
  input wire logic [6:0] rail_good_i,
  input wire pmic_pkg::pmic_cfg_wr_t cfg_i,
  input wire logic int_ack_i,
  input wire logic event_interrupt_n_i,
  output logic [6:0] rail_en_o,
  output logic [6:0][7:0] vsel_o,
  output logic always_on_supply_good_out_o,
  output logic all_rails_good_o,
  output logic processor_wake_input_o,
  output logic event_interrupt_n_o,
  output logic event_interrupt_n_oe_n_o,
  output logic power_led_o
);
  localparam int REQ = 0;
  localparam int BTN = 1;

  function automatic logic [6:0] pmic_step_mask(input logic [2:0] s);
    logic [6:0] m;
    m = '0;
    for (int r = 0; r < pmic_pkg::RAILS; r++) begin
      m[r] = (pmic_pkg::RAIL_STEP[r*3 +: 3] <= s);
    end
    return m;
  endfunction : pmic_step_mask

  // ****************************************************************
  // Synchronisers and debounce
  // ****************************************************************
  logic [1:0] s1;
  logic [1:0] s2;
  logic [6:0] g1;
  logic [6:0] g2;
  logic [1:0] deb;
  logic [1:0] next_deb;
  logic [1:0][31:0] deb_cnt;
  logic [1:0][31:0] next_deb_cnt;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= '0;
      s2 <= '0;
      g1 <= '0;
      g2 <= '0;
    end else begin
      s1 <= {~button_n_i, full_power_request_pin_i};
      s2 <= s1;
      g1 <= rail_good_i;
      g2 <= g1;
    end
  end

  // A level is accepted only after it has held for the whole debounce span
  always_comb begin
    next_deb = deb;
    next_deb_cnt = deb_cnt;
    for (int i = 0; i < 2; i++) begin
      if (s2[i] == deb[i]) begin
        next_deb_cnt[i] = '0;
      end else if (deb_cnt[i] >= DEB_CYC - 1) begin
        next_deb[i] = s2[i];
        next_deb_cnt[i] = '0;
      end else begin
        next_deb_cnt[i] = deb_cnt[i] + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      deb <= '0;
      deb_cnt <= '0;
    end else begin
      deb <= next_deb;
      deb_cnt <= next_deb_cnt;
    end
  end

  // ****************************************************************
  // Sequencer, configuration and events
  // ****************************************************************
  pmic_pkg::pmic_state_t state;
  pmic_pkg::pmic_state_t next_state;
  logic [2:0] step;
  logic [2:0] next_step;
  logic [31:0] tcnt;
  logic [31:0] next_tcnt;
  logic [31:0] hold;
  logic [31:0] next_hold;
  logic btn_d;
  logic next_btn_d;
  logic int_pend;
  logic next_int_pend;
  logic lockout;
  logic next_lockout;
  logic [6:0] rail_sw;
  logic [6:0] next_rail_sw;
  logic [6:0][7:0] next_vsel;
  logic [6:0] next_rail_en;
  logic next_aog;
  logic next_good;
  logic next_led;
  logic press;
  logic long_hit;
  logic [6:0] mask;

  always_comb begin
    next_state = state;
    next_step = step;
    next_tcnt = tcnt;
    next_lockout = lockout;
    next_rail_sw = rail_sw;
    next_vsel = vsel_o;
    next_aog = always_on_supply_good_out_o;
    next_led = power_led_o;
    mask = pmic_step_mask(step);
    press = deb[BTN] & ~btn_d;
    next_btn_d = deb[BTN];
    long_hit = deb[BTN] && (hold == LONG_PRESS_CYC - 1);
    next_hold = !deb[BTN] ? '0 : (hold < LONG_PRESS_CYC ? hold + 32'h1 : hold);
    // A press in the acknowledge cycle still leaves the interrupt pending
    next_int_pend = (int_pend & ~int_ack_i) | press;
    if (cfg_i.valid) begin
      if (cfg_i.addr == pmic_pkg::CFG_RAIL_SW) begin
        next_rail_sw = cfg_i.data[6:0];
      end else if (cfg_i.addr <= pmic_pkg::CFG_VSEL_LAST) begin
        next_vsel[3'(cfg_i.addr - pmic_pkg::CFG_VSEL_FIRST)] = cfg_i.data;
      end
    end
    unique case (state)
      pmic_pkg::S_AO_UP: begin
        if (g2[pmic_pkg::RAIL_AO]) begin
          next_aog = 1'b1;
          next_state = pmic_pkg::S_IDLE;
        end
      end
      pmic_pkg::S_IDLE: begin
        if (!deb[REQ] && !deb[BTN]) begin
          next_lockout = 1'b0;
        end
        if (deb[REQ] && !lockout) begin
          next_step = pmic_pkg::FIRST_STEP;
          next_tcnt = '0;
          next_state = pmic_pkg::S_STROBE;
        end
      end
      pmic_pkg::S_STROBE: begin
        next_tcnt = tcnt + 32'h1;
        if (!deb[REQ]) begin
          next_state = pmic_pkg::S_IDLE;
        end else if (tcnt >= STROBE_CYC - 1 && (g2 & mask) == mask) begin
          next_tcnt = '0;
          if (step == pmic_pkg::LAST_STEP) begin
            next_state = pmic_pkg::S_ON;
            next_led = 1'b1;
          end else begin
            next_step = step + 3'h1;
          end
        end else if (tcnt >= STROBE_CYC + GOOD_TO_CYC) begin
          next_tcnt = '0;
          next_led = 1'b1;
          next_state = pmic_pkg::S_FAULT;
        end
      end
      pmic_pkg::S_ON: begin
        if (!deb[REQ]) begin
          next_led = 1'b0;
          next_state = pmic_pkg::S_IDLE;
        end
      end
      pmic_pkg::S_FAULT: begin
        next_tcnt = tcnt + 32'h1;
        // The single flash ends here; lockout stops an automatic retry
        if (tcnt >= FLASH_CYC - 1) begin
          next_led = 1'b0;
          next_lockout = 1'b1;
          next_state = pmic_pkg::S_IDLE;
        end
      end
    endcase
    if (long_hit && state != pmic_pkg::S_AO_UP) begin
      next_led = 1'b0;
      next_lockout = 1'b1;
      next_state = pmic_pkg::S_IDLE;
    end
    // Always-on rail is forced on in every state, which keeps wake detection alive
    unique case (next_state)
      pmic_pkg::S_STROBE: next_rail_en = pmic_step_mask(next_step);
      pmic_pkg::S_ON: next_rail_en = rail_sw | pmic_pkg::AO_MASK;
      default: next_rail_en = pmic_pkg::AO_MASK;
    endcase
    next_good = (next_state == pmic_pkg::S_ON);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= pmic_pkg::S_AO_UP;
      step <= '0;
      tcnt <= '0;
      hold <= '0;
      btn_d <= 1'b0;
      int_pend <= 1'b0;
      lockout <= 1'b0;
      rail_sw <= pmic_pkg::RAIL_SW_RST;
      vsel_o <= pmic_pkg::VSEL_RST;
      rail_en_o <= pmic_pkg::AO_MASK;
      always_on_supply_good_out_o <= 1'b0;
      all_rails_good_o <= 1'b0;
      processor_wake_input_o <= 1'b0;
      power_led_o <= 1'b0;
    end else begin
      state <= next_state;
      step <= next_step;
      tcnt <= next_tcnt;
      hold <= next_hold;
      btn_d <= next_btn_d;
      int_pend <= next_int_pend;
      lockout <= next_lockout;
      rail_sw <= next_rail_sw;
      vsel_o <= next_vsel;
      rail_en_o <= next_rail_en;
      always_on_supply_good_out_o <= next_aog;
      all_rails_good_o <= next_good;
      processor_wake_input_o <= deb[BTN];
      power_led_o <= next_led;
    end
  end

  // Open drain: pin level is never driven high, only the enable moves
  assign event_interrupt_n_o = 1'b0;
  assign event_interrupt_n_oe_n_o = ~int_pend;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  boot_ao_only_a: assert property ((state == pmic_pkg::S_AO_UP)
    |-> rail_en_o == pmic_pkg::AO_MASK)
    else $error("rail other than always-on enabled at boot");
  supply_good_a: assert property ($rose(always_on_supply_good_out_o) |-> $past(g2[0]))
    else $error("supply-good raised before always-on rail good");
  req_start_a: assert property ((state == pmic_pkg::S_IDLE && deb[REQ] && !lockout
    && !long_hit) |=> state == pmic_pkg::S_STROBE ##1 rail_en_o[pmic_pkg::RAIL_MEM])
    else $error("request did not start the sequence");
  req_drop_a: assert property ((state == pmic_pkg::S_ON && !deb[REQ]) |=> ##1
    (rail_en_o == pmic_pkg::AO_MASK && !all_rails_good_o))
    else $error("request low did not power down");
  // Enables register together with the step, so the current step bounds them
  strobe_order_a: assert property ((state == pmic_pkg::S_STROBE)
    |-> (rail_en_o & ~pmic_step_mask(step)) == 7'h00)
    else $error("rail enabled ahead of its strobe");
  release_a: assert property ($rose(all_rails_good_o) |->
    $past(state == pmic_pkg::S_STROBE && step == pmic_pkg::LAST_STEP))
    else $error("all-rails-good raised without completed sequence");
  wake_a: assert property ($rose(deb[BTN]) |=> processor_wake_input_o)
    else $error("wake not asserted on press");
  int_a: assert property (press |=> !event_interrupt_n_oe_n_o)
    else $error("interrupt not pulled on press");
  int_pin_a: assert property (!event_interrupt_n_oe_n_o |-> !event_interrupt_n_i)
    else $error("interrupt line not low while pulled");
  led_on_a: assert property ($rose(power_led_o) && $past(state == pmic_pkg::S_STROBE)
    |-> state == pmic_pkg::S_ON || state == pmic_pkg::S_FAULT)
    else $error("indicator on without finished procedure");
  fault_flash_a: assert property ($rose(state == pmic_pkg::S_FAULT) |->
    power_led_o ##1 (state == pmic_pkg::S_FAULT) [*1])
    else $error("fault did not flash the indicator");
  cfg_vsel_a: assert property ((cfg_i.valid && cfg_i.addr == 4'h2)
    |=> vsel_o[pmic_pkg::RAIL_MEM] == $past(cfg_i.data))
    else $error("memory rail voltage write lost");
  long_a: assert property ((long_hit && state != pmic_pkg::S_AO_UP)
    |=> state == pmic_pkg::S_IDLE ##1 rail_en_o == pmic_pkg::AO_MASK)
    else $error("long press did not power down");
  // Entry from idle also moves the step, so only steps taken inside the sequence count
  advance_a: assert property ((state == pmic_pkg::S_STROBE && $changed(step)
    && $past(state == pmic_pkg::S_STROBE))
    |-> $past((g2 & mask) == mask && tcnt >= STROBE_CYC - 1))
    else $error("strobe advanced before delay or good");
  deb_a: assert property ($changed(deb[REQ]) |-> $past(deb_cnt[REQ]) >= DEB_CYC - 1)
    else $error("request changed without debounce");

  seq_done_c: cover property (state == pmic_pkg::S_STROBE ##1 state == pmic_pkg::S_ON);
  fault_c: cover property (state == pmic_pkg::S_FAULT ##1 state == pmic_pkg::S_IDLE);
  long_c: cover property (long_hit && state == pmic_pkg::S_ON);
  sleep_c: cover property (state == pmic_pkg::S_ON && rail_en_o == 7'h03);
endmodule : pmic_seq

/* File: test/pmic_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Rail regulators and host request seen from the sequencer
// ****************************************************************
module pmic_host_model #(
  parameter int FAST = 2,
  parameter int SLOW = 11
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [6:0] rail_en_i,
  input wire logic [6:0] fault_i,
  input wire logic slow_i,
  input wire logic want_power_i,
  input wire logic supply_good_i,
  output logic [6:0] rail_good_o,
  output logic full_power_request_o
);
  logic [11:0][6:0] ramp;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ramp <= '0;
    end else begin
      ramp <= {ramp[10:0], rail_en_i};
    end
  end

  // Slow ramp outlasts one strobe gap, so the sequencer must wait on good
  assign rail_good_o = ramp[slow_i ? SLOW : FAST] & rail_en_i & ~fault_i;
  // Host asks only once its clock domain is out of reset; dropping it powers down
  assign full_power_request_o = want_power_i & supply_good_i;
endmodule : pmic_host_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int DEB = 4;
  localparam int STB = 8;
  localparam int FLASH = 10;
  localparam int LONG = 200;
  localparam int STROBE [7] = '{15, 1, 2, 3, 4, 5, 5};
  localparam int MV [7] = '{1800, 1500, 1800, 3300, 3300, 1100, 1100};
  logic ref_clk_i, rst_b_i, want, req, button_n, int_ack, slow, sgood, agr;
  logic wake, int_o, int_oe_n, led;
  logic [6:0] fault, rail_good, rail_en;
  logic [6:0][7:0] vsel;
  pmic_pkg::pmic_cfg_wr_t cfg;
  logic [7:0] exp_vsel [7];
  logic [7:0] lp [2] = '{8'h00, 8'h02};
  int mismatches, checks, cyc;
  // Pull-up on the open-drain interrupt line
  wire int_line = int_oe_n ? 1'b1 : int_o;

  pmic_seq #(.DEB_CYC(DEB), .STROBE_CYC(STB), .GOOD_TO_CYC(50), .FLASH_CYC(FLASH),
    .LONG_PRESS_CYC(LONG)) u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .full_power_request_pin_i(req), .button_n_i(button_n), .rail_good_i(rail_good),
    .cfg_i(cfg), .int_ack_i(int_ack), .event_interrupt_n_i(int_line),
    .rail_en_o(rail_en), .vsel_o(vsel), .always_on_supply_good_out_o(sgood),
    .all_rails_good_o(agr), .processor_wake_input_o(wake), .event_interrupt_n_o(int_o),
    .event_interrupt_n_oe_n_o(int_oe_n), .power_led_o(led));
  pmic_host_model u_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .rail_en_i(rail_en),
    .fault_i(fault), .slow_i(slow), .want_power_i(want), .supply_good_i(sgood),
    .rail_good_o(rail_good), .full_power_request_o(req));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] code(input int mv);
    return 8'(mv / 50);
  endfunction : code
  function automatic logic [6:0] step_mask(input int s);
    logic [6:0] m;
    for (int i = 0; i < 7; i++) m[i] = (STROBE[i] == 15) || (STROBE[i] <= s);
    return m;
  endfunction : step_mask
  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_vsel();
    for (int i = 0; i < 7; i++) chk(64'(vsel[i]), 64'(exp_vsel[i]));
  endtask : chk_vsel
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  task automatic wait_en(input logic [6:0] v, input int lim);
    for (int i = 0; i < lim && rail_en !== v; i++) tick(1);
    chk(rail_en, v);
  endtask : wait_en
  task automatic cfg_wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    cfg = '{valid: 1'b1, addr: a, data: d};
    if (a inside {[4'h1:4'h7]}) exp_vsel[a - 4'h1] = d;
  endtask : cfg_wr
  task automatic cfg_end();
    @(negedge ref_clk_i);
    cfg.valid = 1'b0;
  endtask : cfg_end
  task automatic power_up();
    int s, gap;
    logic [6:0] prev;
    s = 0;
    gap = 0;
    prev = rail_en;
    want = 1'b1;
    for (int i = 0; i < 600 && rail_en !== 7'h7f; i++) begin
      tick(1);
      gap++;
      chk(led, 0);
      if (rail_en !== prev) begin
        s++;
        chk(rail_en, step_mask(s));
        if (s > 1) chk(gap >= STB, 1);
        gap = 0;
        prev = rail_en;
      end
    end
    chk(s, 5);
    for (int i = 0; i < 40 && agr !== 1'b1; i++) tick(1);
    chk(agr, 1);
    chk(led, 1);
  endtask : power_up
  task automatic press();
    button_n = 1'b0;
    for (int i = 0; i < DEB + 8 && wake !== 1'b1; i++) tick(1);
    tick(1);
    chk(wake, 1);
    chk(int_line, 0);
    button_n = 1'b1;
    tick(DEB + 6);
    chk({wake, int_oe_n}, 2'b00);
    int_ack = 1'b1;
    tick(1);
    int_ack = 1'b0;
    tick(1);
    chk(int_oe_n, 1);
  endtask : press

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    int unused, n, hi;
    logic pl;
    logic [3:0] a;
    unused = $urandom(32'he95bf29e);
    {rst_b_i, want, int_ack, slow, pl} = '0;
    button_n = 1'b1;
    fault = '0;
    cfg = '0;
    for (int k = 0; k < 7; k++) exp_vsel[k] = code(MV[k]);
    tick(10);
    chk(rail_en, 7'h01);
    chk_vsel();
    chk({sgood, agr, wake, int_oe_n, led}, 5'b00010);
    rst_b_i = 1'b1;
    for (int i = 0; i < 20 && sgood !== 1'b1; i++) tick(1);
    chk(sgood, 1);
    chk(rail_en, 7'h01);
    // A press shorter than the debounce span must leave wake and interrupt quiet
    button_n = 1'b0;
    tick(2);
    button_n = 1'b1;
    tick(DEB + 6);
    chk({wake, int_oe_n}, 2'b01);
    power_up();
    for (int i = 0; i < 24; i++) begin
      // Core logic rail voltage is never rewritten by software
      do a = 4'($urandom_range(1, 15)); while (a == 4'h6);
      cfg_wr(a, 8'($urandom));
    end
    cfg_wr(4'h2, code(1350));
    cfg_wr(4'h7, code(1300));
    cfg_end();
    chk_vsel();
    foreach (lp[k]) begin
      cfg_wr(4'h0, lp[k]);
      cfg_end();
      tick(2);
      chk(rail_en, lp[k][6:0] | 7'h01);
      press();
    end
    cfg_wr(4'h0, 8'h7f);
    cfg_end();
    tick(2);
    chk(rail_en, 7'h7f);
    want = 1'b0;
    wait_en(7'h01, DEB + 12);
    chk({agr, led}, 2'b00);
    fault = 7'h08;
    want = 1'b1;
    n = 0;
    hi = 0;
    for (int i = 0; i < 300; i++) begin
      tick(1);
      if (led && !pl) n++;
      if (led) hi++;
      pl = led;
    end
    chk(n, 1);
    chk(hi, FLASH);
    chk({rail_en, agr}, {7'h01, 1'b0});
    want = 1'b0;
    fault = '0;
    tick(DEB + 6);
    slow = 1'b1;
    power_up();
    button_n = 1'b0;
    tick(LONG - 20);
    chk(rail_en, 7'h7f);
    wait_en(7'h01, 60);
    chk({agr, led}, 2'b00);
    button_n = 1'b1;
    want = 1'b0;
    int_ack = 1'b1;
    tick(DEB + 6);
    summarize();
  end
endmodule : testbench
